// ===== rtl/frdcs_regs.svh
// Opcodes, field positions and default dummy counts for the dummy-cycle selector
`ifndef FRDCS_REGS_SVH
`define FRDCS_REGS_SVH
`define FRDCS_OP_FAST_READ        8'h0B
`define FRDCS_OP_FAST_READ_DTR    8'h0D
`define FRDCS_OP_DUAL_OUT_READ    8'h3B
`define FRDCS_OP_DUAL_IO_READ     8'hBB
`define FRDCS_OP_DUAL_IO_DTR      8'hBD
`define FRDCS_OP_QUAD_OUT_READ    8'h6B
`define FRDCS_OP_QUAD_IO_READ     8'hEB
`define FRDCS_OP_QUAD_IO_DTR      8'hED
`define FRDCS_OP_UNIQUE_ID_READ   8'h4B
`define FRDCS_OP_DISC_PARAM_READ  8'h5A
`define FRDCS_OP_INFO_ROW_READ    8'h68
`define FRDCS_DUMMY_LSB           3
`define FRDCS_DUMMY_MSB           6
`define FRDCS_PARAM_RESET         8'h00
`define FRDCS_DEF_SPI_FAST        4'h8
`define FRDCS_DEF_QPI_FAST        4'h6
`define FRDCS_DEF_DUAL_IO         4'h4
`define FRDCS_DEF_QUAD_IO         4'h6
`endif

// ===== rtl/frdcs_pkg.sv
// Types shared by the dummy-cycle selector
package frdcs_pkg;
    typedef struct packed {
        logic [7:0] opcode;
        logic       qpi;
        logic [3:0] dummy_field;
    } frdcs_req_t;

    typedef struct packed {
        logic       valid;
        logic       supported;
        logic [3:0] dummy;
    } frdcs_ans_t;

    typedef enum logic [1:0] {
        FRDCS_IDLE  = 2'b00,
        FRDCS_CALC  = 2'b01,
        FRDCS_REPLY = 2'b10
    } frdcs_state_t;
endpackage

// ===== rtl/frdcs_dummy_select.sv
// Dummy-cycle selector: link-side lookup of dummy count per read command
`include "frdcs_regs.svh"

// Notes on behaviour
// - Four-bit field: zero means command default, one to fifteen is the count.
// - Default 8 for single fast, DTR fast, dual and quad output; 6 QPI fast.
// - Default 4 for dual address-data read, normal and double rate.
// - Default 6 for quad address-data read, both rates, single-line or QPI.
// - Dual double-rate read is refused in QPI mode.
// - Single-line unique-ID, parameter and info-row reads follow fast read.
// - QPI unique-ID and info-row reads follow QPI fast read.
module frdcs_dummy_select (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_link_clk,
    input  wire logic                 i_link_rst,
    input  wire logic [7:0]           i_link_opcode,
    input  wire logic                 i_link_qpi,
    input  wire logic                 i_link_strobe,
    input  wire logic [7:0]           i_read_param,
    output logic                      o_link_valid,
    output logic                      o_link_supported,
    output logic [3:0]                o_link_dummy,
    output logic [3:0]                o_core_dummy_field
);

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: read parameter field held for the link side
    logic [3:0] field_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            field_reg <= 4'h0;
        end else begin
            field_reg <= i_read_param[`FRDCS_DUMMY_MSB:`FRDCS_DUMMY_LSB];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_core_dummy_field <= 4'h0;
        end else begin
            o_core_dummy_field <= field_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossing: field passes by a toggle handshake, words stay stable
    logic [3:0] xfer_word_reg;
    logic       xfer_tgl_reg;
    logic       ack_meta_reg;
    logic       ack_sync_reg;
    logic       busy_reg;
    logic       link_ack_tgl_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end else begin
            ack_meta_reg <= link_ack_tgl_reg;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            xfer_word_reg <= 4'h0;
            xfer_tgl_reg  <= 1'b0;
            busy_reg      <= 1'b0;
        end else if (!busy_reg) begin
            if (field_reg != xfer_word_reg) begin
                xfer_word_reg <= field_reg;
                xfer_tgl_reg  <= ~xfer_tgl_reg;
                busy_reg      <= 1'b1;
            end
        end else if (ack_sync_reg == xfer_tgl_reg) begin
            busy_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: receive field
    logic       req_meta_reg;
    logic       req_sync_reg;
    logic [3:0] link_field_reg;

    always_ff @(posedge i_link_clk) begin
        if (i_link_rst) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
        end else begin
            req_meta_reg <= xfer_tgl_reg;
            req_sync_reg <= req_meta_reg;
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (i_link_rst) begin
            link_field_reg   <= 4'h0;
            link_ack_tgl_reg <= 1'b0;
        end else if (req_sync_reg != link_ack_tgl_reg) begin
            link_field_reg   <= xfer_word_reg;
            link_ack_tgl_reg <= req_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: per-command default lookup
    frdcs_pkg::frdcs_req_t req;
    frdcs_pkg::frdcs_ans_t ans_next;

    assign req.opcode      = i_link_opcode;
    assign req.qpi         = i_link_qpi;
    assign req.dummy_field = link_field_reg;

    always_comb begin
        ans_next.valid     = i_link_strobe;
        ans_next.supported = 1'b1;
        ans_next.dummy     = 4'h0;
        unique case (req.opcode)
            `FRDCS_OP_FAST_READ,
            `FRDCS_OP_FAST_READ_DTR: begin
                ans_next.dummy = req.qpi ? `FRDCS_DEF_QPI_FAST : `FRDCS_DEF_SPI_FAST;
            end
            `FRDCS_OP_UNIQUE_ID_READ,
            `FRDCS_OP_INFO_ROW_READ: begin
                ans_next.dummy = req.qpi ? `FRDCS_DEF_QPI_FAST : `FRDCS_DEF_SPI_FAST;
            end
            `FRDCS_OP_DISC_PARAM_READ: begin
                ans_next.dummy     = `FRDCS_DEF_SPI_FAST;
                ans_next.supported = !req.qpi;
            end
            `FRDCS_OP_DUAL_OUT_READ,
            `FRDCS_OP_QUAD_OUT_READ: begin
                ans_next.dummy = `FRDCS_DEF_SPI_FAST;
            end
            `FRDCS_OP_DUAL_IO_READ: begin
                ans_next.dummy = `FRDCS_DEF_DUAL_IO;
            end
            `FRDCS_OP_DUAL_IO_DTR: begin
                ans_next.dummy     = `FRDCS_DEF_DUAL_IO;
                ans_next.supported = !req.qpi;
            end
            `FRDCS_OP_QUAD_IO_READ,
            `FRDCS_OP_QUAD_IO_DTR: begin
                ans_next.dummy = `FRDCS_DEF_QUAD_IO;
            end
            default: begin
                ans_next.supported = 1'b0;
            end
        endcase
        if (req.dummy_field != 4'h0) begin
            ans_next.dummy = req.dummy_field;
        end
        if (!ans_next.supported) begin
            ans_next.dummy = 4'h0;
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (i_link_rst) begin
            o_link_valid     <= 1'b0;
            o_link_supported <= 1'b0;
            o_link_dummy     <= 4'h0;
        end else begin
            o_link_valid     <= ans_next.valid;
            o_link_supported <= ans_next.valid & ans_next.supported;
            o_link_dummy     <= ans_next.valid ? ans_next.dummy : 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_dual_dtr_qpi;
        i_link_strobe && i_link_qpi && (i_link_opcode == `FRDCS_OP_DUAL_IO_DTR);
    endsequence

    chk_dual_dtr_refused: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        s_dual_dtr_qpi |=> o_link_valid && !o_link_supported)
        else $error("dual double-rate read accepted in QPI");

    chk_dual_default: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && !i_link_qpi && link_field_reg == 4'h0 && i_link_opcode == `FRDCS_OP_DUAL_IO_READ)
        |=> o_link_dummy == 4'h4)
        else $error("dual address-data default not four");

    chk_quad_default: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && link_field_reg == 4'h0 && i_link_opcode == `FRDCS_OP_QUAD_IO_DTR)
        |=> o_link_dummy == 4'h6)
        else $error("quad address-data default not six");

    chk_fast_default: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && !i_link_qpi && link_field_reg == 4'h0 && i_link_opcode == `FRDCS_OP_FAST_READ)
        |=> o_link_dummy == 4'h8)
        else $error("single fast read default not eight");

    chk_qpi_default: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && i_link_qpi && link_field_reg == 4'h0 && i_link_opcode == `FRDCS_OP_FAST_READ_DTR)
        |=> o_link_dummy == 4'h6)
        else $error("QPI fast read default not six");

    chk_field_override: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && link_field_reg != 4'h0 && i_link_opcode == `FRDCS_OP_QUAD_OUT_READ)
        |=> o_link_dummy == $past(link_field_reg))
        else $error("explicit dummy count not used");

    // parameter read follows single fast read
    chk_param_follow: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && !i_link_qpi && link_field_reg == 4'h0 && i_link_opcode == `FRDCS_OP_DISC_PARAM_READ)
        |=> o_link_supported && o_link_dummy == 4'h8)
        else $error("parameter read dummy differs from fast read");

    // QPI unique-ID follows QPI fast read
    chk_qpi_uid_follow: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && i_link_qpi && link_field_reg == 4'h0 && i_link_opcode == `FRDCS_OP_UNIQUE_ID_READ)
        |=> o_link_dummy == 4'h6)
        else $error("QPI unique-ID dummy differs from fast read");

    // single-line unique-ID and info-row follow fast read
    chk_spi_id_follow: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && !i_link_qpi && link_field_reg == 4'h0
            && i_link_opcode inside {`FRDCS_OP_UNIQUE_ID_READ, `FRDCS_OP_INFO_ROW_READ})
        |=> o_link_supported && o_link_dummy == 4'h8)
        else $error("single-line identity read dummy differs from fast read");

    // QPI info-row follows QPI fast read
    chk_qpi_row_follow: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && i_link_qpi && link_field_reg == 4'h0 && i_link_opcode == `FRDCS_OP_INFO_ROW_READ)
        |=> o_link_supported && o_link_dummy == 4'h6)
        else $error("QPI info-row dummy differs from fast read");

    chk_output_default: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && !i_link_qpi && link_field_reg == 4'h0
            && i_link_opcode inside {`FRDCS_OP_DUAL_OUT_READ, `FRDCS_OP_QUAD_OUT_READ})
        |=> o_link_supported && o_link_dummy == 4'h8)
        else $error("output read default not eight");

    // quad normal rate default six in any mode
    chk_quad_io_default: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && link_field_reg == 4'h0 && i_link_opcode == `FRDCS_OP_QUAD_IO_READ)
        |=> o_link_supported && o_link_dummy == 4'h6)
        else $error("quad address-data normal default not six");

    // dual double rate accepted on single line
    chk_dual_dtr_spi: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (i_link_strobe && !i_link_qpi && link_field_reg == 4'h0 && i_link_opcode == `FRDCS_OP_DUAL_IO_DTR)
        |=> o_link_supported && o_link_dummy == 4'h4)
        else $error("dual double-rate default not four on single line");

    chk_refused_zero: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (o_link_valid && !o_link_supported)
        |-> o_link_dummy == 4'h0)
        else $error("refused answer carries a dummy count");

    // one answer per strobe, next cycle
    chk_valid_follows: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        1'b1
        |-> o_link_valid == $past(i_link_strobe))
        else $error("answer pulse does not follow strobe");

    chk_idle_quiet: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        !o_link_valid
        |-> !o_link_supported && o_link_dummy == 4'h0)
        else $error("answer outputs not quiet while idle");

    // nonzero field overrides every supported command
    chk_override_all: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
        (o_link_valid && o_link_supported && $past(link_field_reg) != 4'h0)
        |-> o_link_dummy == $past(link_field_reg))
        else $error("nonzero field not used as dummy count");

    // core copy of the field lags two clocks
    chk_core_field: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!$past(i_rst) && !$past(i_rst, 2))
        |-> o_core_dummy_field == $past(i_read_param[`FRDCS_DUMMY_MSB:`FRDCS_DUMMY_LSB], 2))
        else $error("core field copy wrong");

    // crossing word holds while the handshake runs
    chk_xfer_stable: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (busy_reg && $past(busy_reg))
        |-> $stable(xfer_word_reg))
        else $error("crossing word changed during handshake");

    // field reaches link side in bounded time
    chk_field_cross: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(busy_reg) |-> ##[1:40] !busy_reg)
        else $error("dummy field crossing stalled");

endmodule // frdcs_dummy_select

// ===== verification/frdcs_host_model.sv
// Host flash controller model issuing read-command lookups on the link clock
module frdcs_host_model (
    input  wire logic       i_link_clk,
    output logic [7:0]      o_opcode,
    output logic            o_qpi,
    output logic            o_strobe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_opcode = 8'h00;
        o_qpi    = 1'b0;
        o_strobe = 1'b0;
    end

    // caller picks opcode, mode and whether the strobe drops after the edge
    task automatic send(input logic [7:0] op, input logic qpi, input logic last);
        o_opcode = op;
        o_qpi    = qpi;
        o_strobe = 1'b1;
        @(posedge i_link_clk);
        #1;
        if (last) begin
            // released opcode and strobe lines never keep the old value; qpi keeps its value
            o_opcode = ~op;
            o_strobe = 1'b0;
        end
    endtask
endmodule // frdcs_host_model

// ===== verification/frdcs_dummy_select_tb.sv
// Self-checking bench for the dummy-cycle selector
module frdcs_dummy_select_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 core_clk;
    logic                 link_clk;
    logic                 rst;
    logic                 link_rst;
    logic [7:0]           read_param;
    logic [7:0]           link_opcode;
    logic                 link_qpi;
    logic                 link_strobe;
    logic                 link_valid;
    logic                 link_supported;
    logic [3:0]           link_dummy;
    logic [3:0]           core_field;
    int                   miscompares = 0;
    int                   compares = 0;
    frdcs_pkg::frdcs_ans_t expq[$];
    frdcs_pkg::frdcs_ans_t got_ans;
    logic [3:0]           fields[3] = '{4'h0, 4'h1, 4'hF};
    // rows: opcode, qpi bit 5, supported bit 4, default count
    logic [15:0]          rows[20] = '{16'h0B18, 16'h0B36, 16'h0D18, 16'h0D36, 16'h3B18, 16'h6B18, 16'hBB14,
        16'hBD14, 16'hBD20, 16'hEB16, 16'hEB36, 16'hED16, 16'hED36, 16'h4B18, 16'h4B36, 16'h5A18, 16'h5A20,
        16'h6818, 16'h6836, 16'h0000};

    frdcs_host_model u_frdcs_host_model (.i_link_clk(link_clk), .o_opcode(link_opcode), .o_qpi(link_qpi),
        .o_strobe(link_strobe));

    frdcs_dummy_select u_frdcs_dummy_select (.i_core_clk(core_clk), .i_rst(rst), .i_link_clk(link_clk),
        .i_link_rst(link_rst), .i_link_opcode(link_opcode), .i_link_qpi(link_qpi), .i_link_strobe(link_strobe),
        .i_read_param(read_param), .o_link_valid(link_valid), .o_link_supported(link_supported),
        .o_link_dummy(link_dummy), .o_core_dummy_field(core_field));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        link_clk = 1'b0;
        #7.3;
        forever #15 link_clk = ~link_clk;
    end

    task automatic check1(input string name, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", name, e, g);
        end
    endtask

    task automatic check4(input string name, input logic [3:0] e, input logic [3:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", name, e, g);
        end
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Each answer pulse is matched against the oldest request, mid-cycle where it has settled
    always @(negedge link_clk) begin
        if (link_valid !== 1'b0) begin
            if (expq.size() == 0) begin
                check1("valid", 1'b0, link_valid);
            end else begin
                got_ans = expq.pop_front();
                check1("supported", got_ans.supported, link_supported);
                check4("dummy", got_ans.dummy, link_dummy);
            end
        end
    end

    task automatic set_field(input logic [3:0] f);
        @(posedge core_clk);
        #1;
        read_param = {1'b0, f, 3'b000};
        repeat (8) @(posedge link_clk);
        check4("core field", f, core_field);
        #1;
    endtask

    task automatic lookup(input logic [15:0] r, input logic [3:0] f, input logic last);
        expq.push_back({1'b1, r[4], r[4] ? ((f != 4'h0) ? f : r[3:0]) : 4'h0});
        u_frdcs_host_model.send(r[15:8], r[5], last);
    endtask

    task automatic drain();
        for (int i = 0; i < 20 && expq.size() != 0; i++) begin
            @(posedge link_clk);
        end
        if (expq.size() != 0) begin
            miscompares++;
            $display("mismatch answers expected 0 seen %0d", expq.size());
            report_and_stop();
        end
    endtask

    task automatic do_reset();
        #1;
        rst = 1'b1;
        link_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        repeat (2) @(posedge link_clk);
        #1;
        check1("valid in reset", 1'b0, link_valid);
        check1("supported in reset", 1'b0, link_supported);
        check4("dummy in reset", 4'h0, link_dummy);
        check4("field in reset", 4'h0, core_field);
        @(posedge core_clk);
        #1;
        rst = 1'b0;
        @(posedge link_clk);
        #1;
        link_rst = 1'b0;
    endtask

    initial begin
        read_param = 8'h00;
        do_reset();
        foreach (fields[k]) begin
            set_field(fields[k]);
            foreach (rows[j]) begin
                lookup(rows[j], fields[k], 1'b1);
                @(posedge link_clk);
                #1;
            end
            drain();
        end
        set_field(4'h0);
        // back-to-back lookups answer on consecutive cycles
        lookup(16'hBB14, 4'h0, 1'b0);
        lookup(16'hED36, 4'h0, 1'b1);
        drain();
        // reset clears a nonzero field; first strobe right after release uses default
        set_field(4'hF);
        do_reset();
        lookup(16'h0B18, 4'h0, 1'b1);
        drain();
        set_field(4'h0);
        lookup(16'hEB16, 4'h0, 1'b1);
        drain();
        report_and_stop();
    end
endmodule // frdcs_dummy_select_tb
